/* File: hw/drs_rank_select_cfg.sv */
// Functional notes
// - Base register bits 13:5 hold rank base address bits 21:13, writable.
// - Mirror bit 3 set: swap address and bank pins on mode-set commands.
// - Swap bank 0 with 1, address 3/4, 5/6 and 7/8.
// - Bit 1 of a base register marks the reserve rank for sparing.
// - Bit 0 of a base register enables the rank; bit 4 is reserved.
// - Mask bits 28:19 cover address 36:27, bits 13:5 cover 21:13.
// - Every mask register resets to zero.
// - Channel control register resets to six.
// - Control bits 31:22 hold the writable worst-case read round-trip limit.
// - The limit counts controller clock cycles for the whole read path.
// - Select a rank when enabled and unmasked address bits equal its base.
// - Base register bits 28:19 hold rank base address bits 36:27, writable.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module drs_rank_select_cfg #(
  parameter int RANKS = drs_pkg::NUM_RANKS,
  parameter int AW = drs_pkg::CMD_ADDR_W,
  parameter int BW = drs_pkg::CMD_BANK_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reqValid,
  input wire logic [drs_pkg::NADDR_W-1:0] normalizedRequestAddr,
  output logic [RANKS-1:0] rankSelectOut,
  output logic rankSelectValid,
  input wire logic cmdValid,
  input wire logic cmdIsModeSet,
  input wire logic [$clog2(RANKS)-1:0] cmdRank,
  input wire logic [AW-1:0] cmdAddr,
  input wire logic [BW-1:0] cmdBank,
  output logic memCmdValid,
  output logic [AW-1:0] memAddrOut,
  output logic [BW-1:0] memBankOut,
  input wire logic readIssue,
  input wire logic readRespond,
  output logic readRoundtripExpired,
  output logic [RANKS-1:0] reserveRankOut,
  output logic [RANKS-1:0] rankCheckFailedOut
);

  //////////////////////////////////////////////////////////////////////////
  // Elaboration checks: the map holds eight base words and four mask words,
  // and the swap touches address pins up to 8 and bank pin 1.
  if (RANKS < 2 || RANKS > 8 || (RANKS % 2) != 0) begin : gBadRanks
    $error("RANKS must be even and between 2 and 8");
  end
  if (AW < 9 || BW < 2) begin : gBadPins
    $error("command address needs 9 bits and bank needs 2 bits");
  end

  localparam int RI_W = $clog2(RANKS);
  localparam int LW = drs_pkg::LAT_W;
  localparam logic [5:0] BASE_W = drs_pkg::OFF_BASE0[7:2];
  localparam logic [5:0] BASE_L = 6'(BASE_W + 6'(RANKS - 1));
  localparam logic [5:0] MASK_W = drs_pkg::OFF_MASK0[7:2];
  localparam logic [5:0] MASK_L = 6'(MASK_W + 6'(RANKS / 2 - 1));
  localparam logic [5:0] CTRL_W = drs_pkg::OFF_CTRL[7:2];
  localparam logic [5:0] STAT_W = drs_pkg::OFF_STATUS[7:2];

  typedef struct packed {
    logic [RANKS-1:0][31:0] base;
    logic [RANKS/2-1:0][31:0] mask;
    logic [31:0] ctrl;
    logic ack;
    logic [31:0] rdata;
    drs_pkg::drs_wait_t wst;
    logic [LW-1:0] waitCnt;
    logic expired;
    logic late;
    logic cmdVld;
    logic [AW-1:0] cmdAddr;
    logic [BW-1:0] cmdBank;
  } drs_state_t;

  drs_state_t st_r;
  drs_state_t st_nxt;

  drs_cfg_if #(.RANKS(RANKS)) cfgBus ();

  logic [5:0] wordAdr;
  logic [RI_W-1:0] baseIdx;
  logic [RI_W-1:0] maskIdx;
  logic busReq;
  logic [31:0] readWord;
  logic [LW-1:0] limit;
  logic swapNow;

  //////////////////////////////////////////////////////////////////////////
  // Byte-lane merge that also keeps reserved bits at zero.
  function automatic logic [31:0] mergeLanes(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] sel,
    input logic [31:0] rwMask
  );
    logic [31:0] lanes;
    for (int i = 0; i < 4; i++) begin
      lanes[i*8 +: 8] = {8{sel[i]}};
    end
    return (oldVal & ~(lanes & rwMask)) | (newVal & lanes & rwMask);
  endfunction : mergeLanes

  // Mirrored module routing: bank 0/1 and address 3/4, 5/6, 7/8 cross.
  function automatic logic [AW-1:0] swapAddr(input logic [AW-1:0] a);
    logic [AW-1:0] o;
    o = a;
    o[3] = a[4];
    o[4] = a[3];
    o[5] = a[6];
    o[6] = a[5];
    o[7] = a[8];
    o[8] = a[7];
    return o;
  endfunction : swapAddr

  function automatic logic [BW-1:0] swapBank(input logic [BW-1:0] b);
    logic [BW-1:0] o;
    o = b;
    o[0] = b[1];
    o[1] = b[0];
    return o;
  endfunction : swapBank

  //////////////////////////////////////////////////////////////////////////
  // Bus decode and read mux.
  always_comb begin
    wordAdr = wb_adr_i[7:2];
    baseIdx = RI_W'(wordAdr - BASE_W);
    maskIdx = RI_W'(wordAdr - MASK_W);
    busReq = wb_cyc_i & wb_stb_i & ~st_r.ack;
    limit = st_r.ctrl[drs_pkg::LAT_MSB:drs_pkg::LAT_LSB];
    readWord = 32'h0000_0000;
    if (wordAdr >= BASE_W && wordAdr <= BASE_L) begin
      readWord = st_r.base[baseIdx] & drs_pkg::BASE_RW;
    end else if (wordAdr >= MASK_W && wordAdr <= MASK_L) begin
      readWord = st_r.mask[maskIdx] & drs_pkg::MASK_RW;
    end else if (wordAdr == CTRL_W) begin
      readWord = st_r.ctrl & drs_pkg::CTRL_RW;
    end else if (wordAdr == STAT_W) begin
      readWord[RANKS-1:0] = cfgBus.select;
      readWord[drs_pkg::ST_WAIT_BIT] = (st_r.wst == drs_pkg::DRS_WAIT);
      readWord[drs_pkg::ST_LATE_BIT] = st_r.late;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.expired = 1'b0;
    swapNow = 1'b0;

    // Register access: answered one cycle after the request is seen, with
    // the store done on that same edge so the master may read back at once.
    if (busReq) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = wb_we_i ? 32'h0000_0000 : readWord;
      if (wb_we_i) begin
        if (wordAdr >= BASE_W && wordAdr <= BASE_L) begin
          st_nxt.base[baseIdx] = mergeLanes(st_r.base[baseIdx], wb_dat_i,
            wb_sel_i, drs_pkg::BASE_RW);
        end else if (wordAdr >= MASK_W && wordAdr <= MASK_L) begin
          st_nxt.mask[maskIdx] = mergeLanes(st_r.mask[maskIdx], wb_dat_i,
            wb_sel_i, drs_pkg::MASK_RW);
        end else if (wordAdr == CTRL_W) begin
          st_nxt.ctrl = mergeLanes(st_r.ctrl, wb_dat_i, wb_sel_i,
            drs_pkg::CTRL_RW);
        end else if (wordAdr == STAT_W) begin
          if (wb_sel_i[1] && wb_dat_i[drs_pkg::ST_LATE_BIT]) begin
            st_nxt.late = 1'b0;
          end
        end
      end
    end

    // Command pins: only mode-set commands to a mirrored rank are crossed,
    // so normal traffic keeps the direct routing.
    st_nxt.cmdVld = cmdValid;
    if (cmdValid) begin
      swapNow = cmdIsModeSet && st_r.base[cmdRank][drs_pkg::BIT_SWAP];
      if (swapNow) begin
        st_nxt.cmdAddr = swapAddr(cmdAddr);
        st_nxt.cmdBank = swapBank(cmdBank);
      end else begin
        st_nxt.cmdAddr = cmdAddr;
        st_nxt.cmdBank = cmdBank;
      end
    end

    // Round-trip watchdog in controller clocks; a zero limit disables it,
    // which keeps a freshly reset part from flagging every read.
    case (st_r.wst)
      drs_pkg::DRS_IDLE: begin
        if (readIssue && limit != '0) begin
          st_nxt.wst = drs_pkg::DRS_WAIT;
          st_nxt.waitCnt = LW'(1);
        end
      end
      drs_pkg::DRS_WAIT: begin
        if (readRespond) begin
          st_nxt.wst = drs_pkg::DRS_IDLE;
        end else if (st_r.waitCnt == limit) begin
          st_nxt.expired = 1'b1;
          st_nxt.late = 1'b1;
          st_nxt.wst = drs_pkg::DRS_IDLE;
        end else begin
          st_nxt.waitCnt = LW'(st_r.waitCnt + 1'b1);
        end
      end
      default: begin
        st_nxt.wst = drs_pkg::DRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      for (int r = 0; r < RANKS; r++) begin
        st_r.base[r] <= drs_pkg::BASE_RESET;
      end
      for (int m = 0; m < RANKS / 2; m++) begin
        st_r.mask[m] <= drs_pkg::MASK_RESET;
      end
      st_r.ctrl <= drs_pkg::CTRL_RESET;
      st_r.wst <= drs_pkg::DRS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration fan-out to the matcher and flag outputs.
  for (genvar r = 0; r < RANKS; r++) begin : gCfg
    assign cfgBus.rankBaseHi[r] = st_r.base[r][drs_pkg::HI_MSB:drs_pkg::HI_LSB];
    assign cfgBus.rankBaseLo[r] = st_r.base[r][drs_pkg::LO_MSB:drs_pkg::LO_LSB];
    assign cfgBus.rankSelectOn[r] = st_r.base[r][drs_pkg::BIT_ENABLE];
    assign reserveRankOut[r] = st_r.base[r][drs_pkg::BIT_RESERVE];
    assign rankCheckFailedOut[r] = st_r.base[r][drs_pkg::BIT_FAIL];
    if ((r % 2) == 0) begin : gMask
      assign cfgBus.rankIgnoreHi[r/2] =
        st_r.mask[r/2][drs_pkg::HI_MSB:drs_pkg::HI_LSB];
      assign cfgBus.rankIgnoreLo[r/2] =
        st_r.mask[r/2][drs_pkg::LO_MSB:drs_pkg::LO_LSB];
    end
  end

  assign cfgBus.reqValid = reqValid;
  assign cfgBus.reqAddr = normalizedRequestAddr;

  drs_rank_match #(
    .RANKS(RANKS)
  ) uMatch (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .cfg(cfgBus.match)
  );

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;
  assign rankSelectOut = cfgBus.select;
  assign rankSelectValid = cfgBus.selValid;
  assign memCmdValid = st_r.cmdVld;
  assign memAddrOut = st_r.cmdAddr;
  assign memBankOut = st_r.cmdBank;
  assign readRoundtripExpired = st_r.expired;

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  logic firstCycle_r;
  logic mirrorSel;
  logic baseWr0;
  logic maskWr0;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      firstCycle_r <= 1'b1;
    end else begin
      firstCycle_r <= 1'b0;
    end
  end

  assign mirrorSel = st_r.base[cmdRank][drs_pkg::BIT_SWAP];
  assign baseWr0 = wb_ack_o && wb_we_i && wb_adr_i == drs_pkg::OFF_BASE0;
  assign maskWr0 = wb_ack_o && wb_we_i && wb_adr_i == drs_pkg::OFF_MASK0;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_base_lo_write: assert property (
    baseWr0 && wb_sel_i[1:0] == 2'b11 |->
    st_r.base[0][13:5] == wb_dat_i[13:5])
    else $error("base low field not stored");

  a_base_hi_write: assert property (
    baseWr0 && wb_sel_i[3:2] == 2'b11 |->
    st_r.base[0][28:19] == wb_dat_i[28:19])
    else $error("base high field not stored");

  a_enable_flags: assert property (
    baseWr0 && wb_sel_i[0] |->
    cfgBus.rankSelectOn[0] == wb_dat_i[0] && st_r.base[0][4] == 1'b0)
    else $error("rank enable wrong or reserved bit set");

  a_reserve_rank: assert property (
    baseWr0 && wb_sel_i[0] |-> reserveRankOut[0] == wb_dat_i[1])
    else $error("reserve rank flag not stored");

  a_mask_fields: assert property (
    maskWr0 && wb_sel_i == 4'hF |->
    st_r.mask[0] == (wb_dat_i & 32'h1FF8_3FE0))
    else $error("mask register fields wrong");

  a_reserved_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] == CTRL_W |->
    (wb_dat_o & ~drs_pkg::CTRL_RW) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");

  a_reset_values: assert property (
    firstCycle_r |-> st_r.ctrl == 32'h0000_0006 && st_r.mask == '0)
    else $error("reset values wrong");

  a_mrs_swap: assert property (
    cmdValid && cmdIsModeSet && mirrorSel |=>
    memAddrOut[3] == $past(cmdAddr[4]) && memAddrOut[8] == $past(cmdAddr[7])
    && memBankOut[1] == $past(cmdBank[0]) && memCmdValid)
    else $error("mode-set pins not swapped");

  a_mrs_direct: assert property (
    cmdValid && cmdIsModeSet && !mirrorSel |=>
    memAddrOut == $past(cmdAddr) && memBankOut == $past(cmdBank))
    else $error("unmirrored mode-set altered");

  a_plain_direct: assert property (
    cmdValid && !cmdIsModeSet |=>
    memAddrOut == $past(cmdAddr) && memBankOut == $past(cmdBank))
    else $error("normal command altered");

  a_limit_expiry: assert property (
    st_r.wst == drs_pkg::DRS_WAIT && !readRespond && st_r.waitCnt == limit
    |=> readRoundtripExpired ##1 !readRoundtripExpired)
    else $error("watchdog did not fire once at limit");

  a_limit_field: assert property (
    readRoundtripExpired |-> $past(st_r.waitCnt) == $past(limit))
    else $error("watchdog fired off the programmed limit");

  c_mrs_mirrored: cover property (cmdValid && cmdIsModeSet && mirrorSel);
  c_expired: cover property (readRoundtripExpired);
  c_rank_hit: cover property (|rankSelectOut);
  c_unmapped: cover property (wb_ack_o && wb_adr_i == 8'h90);

endmodule : drs_rank_select_cfg

/* File: hw/drs_pkg.sv */
package drs_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Geometry and widths.
  localparam int NUM_RANKS = 8;
  localparam int NADDR_W = 37;
  localparam int CMD_ADDR_W = 16;
  localparam int CMD_BANK_W = 3;
  localparam int LAT_W = 10;

  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFF_BASE0 = 8'h40;
  localparam logic [7:0] OFF_MASK0 = 8'h60;
  localparam logic [7:0] OFF_CTRL = 8'h78;
  localparam logic [7:0] OFF_STATUS = 8'h80;

  //////////////////////////////////////////////////////////////////////////
  // Reset values and writable-bit masks.
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0006;
  localparam logic [31:0] BASE_RW = 32'h1FF8_3FEF;
  localparam logic [31:0] MASK_RW = 32'h1FF8_3FE0;
  localparam logic [31:0] CTRL_RW = 32'hFFCC_BFFF;

  //////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int HI_LSB = 19;
  localparam int HI_MSB = 28;
  localparam int LO_LSB = 5;
  localparam int LO_MSB = 13;
  localparam int ADDR_HI_LSB = 27;
  localparam int ADDR_HI_MSB = 36;
  localparam int ADDR_LO_LSB = 13;
  localparam int ADDR_LO_MSB = 21;
  localparam int BIT_SWAP = 3;
  localparam int BIT_FAIL = 2;
  localparam int BIT_RESERVE = 1;
  localparam int BIT_ENABLE = 0;
  localparam int LAT_LSB = 22;
  localparam int LAT_MSB = 31;
  localparam int ST_WAIT_BIT = 8;
  localparam int ST_LATE_BIT = 9;

  typedef enum logic {DRS_IDLE, DRS_WAIT} drs_wait_t;

endpackage : drs_pkg

/* File: hw/drs_cfg_if.sv */
`timescale 1ns/1ps
interface drs_cfg_if #(
  parameter int RANKS = drs_pkg::NUM_RANKS
);
  logic [RANKS-1:0][drs_pkg::HI_MSB-drs_pkg::HI_LSB:0] rankBaseHi;
  logic [RANKS-1:0][drs_pkg::LO_MSB-drs_pkg::LO_LSB:0] rankBaseLo;
  logic [RANKS-1:0] rankSelectOn;
  logic [RANKS/2-1:0][drs_pkg::HI_MSB-drs_pkg::HI_LSB:0] rankIgnoreHi;
  logic [RANKS/2-1:0][drs_pkg::LO_MSB-drs_pkg::LO_LSB:0] rankIgnoreLo;
  logic reqValid;
  logic [drs_pkg::NADDR_W-1:0] reqAddr;
  logic [RANKS-1:0] select;
  logic selValid;

  modport cfg (
    output rankBaseHi, rankBaseLo, rankSelectOn, rankIgnoreHi, rankIgnoreLo,
    output reqValid, reqAddr,
    input select, selValid
  );

  modport match (
    input rankBaseHi, rankBaseLo, rankSelectOn, rankIgnoreHi, rankIgnoreLo,
    input reqValid, reqAddr,
    output select, selValid
  );
endinterface : drs_cfg_if

/* File: hw/drs_rank_match.sv */
`timescale 1ns/1ps
module drs_rank_match #(
  parameter int RANKS = drs_pkg::NUM_RANKS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  drs_cfg_if.match cfg
);

  typedef struct packed {
    logic [RANKS-1:0] select;
    logic selValid;
  } drs_match_t;

  drs_match_t st_r;
  drs_match_t st_nxt;
  logic [RANKS-1:0] hit;

  //////////////////////////////////////////////////////////////////////////
  // Both ranks of a module pair share one ignore mask.
  for (genvar r = 0; r < RANKS; r++) begin : gRank
    localparam int M = r / 2;
    logic hiEq;
    logic loEq;
    assign hiEq = ((cfg.reqAddr[drs_pkg::ADDR_HI_MSB:drs_pkg::ADDR_HI_LSB]
                    & ~cfg.rankIgnoreHi[M]) ==
                   (cfg.rankBaseHi[r] & ~cfg.rankIgnoreHi[M]));
    assign loEq = ((cfg.reqAddr[drs_pkg::ADDR_LO_MSB:drs_pkg::ADDR_LO_LSB]
                    & ~cfg.rankIgnoreLo[M]) ==
                   (cfg.rankBaseLo[r] & ~cfg.rankIgnoreLo[M]));
    assign hit[r] = cfg.rankSelectOn[r] & hiEq & loEq;
  end

  always_comb begin
    st_nxt.selValid = cfg.reqValid;
    st_nxt.select = cfg.reqValid ? hit : '0;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg.select = st_r.select;
  assign cfg.selValid = st_r.selValid;

  //////////////////////////////////////////////////////////////////////////
  a_select_disabled: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    cfg.reqValid && cfg.rankSelectOn == '0 |=> cfg.select == '0)
    else $error("rank selected while every rank is disabled");

  a_select_valid: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (|cfg.select) |-> cfg.selValid && $past(cfg.reqValid))
    else $error("rank select without a request");

endmodule : drs_rank_match

/* File: test/drs_dram_model.sv */
`timescale 1ns/1ps
module drs_dram_model #(
  parameter int AW = drs_pkg::CMD_ADDR_W,
  parameter int BW = drs_pkg::CMD_BANK_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic memCmdValid,
  input wire logic [AW-1:0] memAddrOut,
  input wire logic [BW-1:0] memBankOut,
  output logic [AW-1:0] lastAddr,
  output logic [BW-1:0] lastBank,
  output logic [7:0] cmdCount
);
  // The module latches pins only on a valid command, as a rank would.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lastAddr <= '0;
      lastBank <= '0;
      cmdCount <= '0;
    end else if (memCmdValid) begin
      lastAddr <= memAddrOut;
      lastBank <= memBankOut;
      cmdCount <= cmdCount + 8'h01;
    end
  end
endmodule : drs_dram_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rst_b, cyc, stb, we, reqValid, cmdValid, cmdIsModeSet;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datI, datO;
  logic ack, selValid, memCmdValid, rdIssue, rdResp, expired;
  logic [36:0] reqAddr;
  logic [7:0] rankSel, reserveOut, failOut, cmdCount;
  logic [2:0] cmdRank, cmdBank, memBank, lastBank;
  logic [15:0] cmdAddr, memAddr, lastAddr;
  int err_count = 0;
  int num_checks = 0;

  drs_rank_select_cfg i_drs_rank_select_cfg (.ref_clk(ref_clk),
    .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .reqValid(reqValid), .normalizedRequestAddr(reqAddr),
    .rankSelectOut(rankSel), .rankSelectValid(selValid),
    .cmdValid(cmdValid), .cmdIsModeSet(cmdIsModeSet), .cmdRank(cmdRank),
    .cmdAddr(cmdAddr), .cmdBank(cmdBank), .memCmdValid(memCmdValid),
    .memAddrOut(memAddr), .memBankOut(memBank), .readIssue(rdIssue),
    .readRespond(rdResp), .readRoundtripExpired(expired),
    .reserveRankOut(reserveOut), .rankCheckFailedOut(failOut));

  drs_dram_model i_drs_dram_model (.ref_clk(ref_clk), .rst_b(rst_b),
    .memCmdValid(memCmdValid), .memAddrOut(memAddr), .memBankOut(memBank),
    .lastAddr(lastAddr), .lastBank(lastBank), .cmdCount(cmdCount));

  //////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // The request stands until the edge that samples ack high; read data is
  // taken at that same edge, and only then is the request released.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [3:0] s, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    datI <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      wrap_up();
    end
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, 4'hF, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 4'hF, 32'h0000_0000, q);
    check(q, e);
  endtask : rd_chk

  function automatic logic [31:0] baseVal(input logic [9:0] h,
                                          input logic [8:0] l);
    return {3'b000, h, 5'b0_0000, l, 5'b0_0000};
  endfunction : baseVal

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rd_chk(8'h40 + 8'(4 * i), 32'h0000_0000);
    for (int i = 0; i < 4; i++) rd_chk(8'h60 + 8'(4 * i), 32'h0000_0000);
    rd_chk(8'h78, 32'h0000_0006);
    $display("test reset done");
  endtask : t_reset

  task automatic t_access;
    logic [31:0] q;
    wr(8'h5C, 32'hFFFF_FFFF);
    rd_chk(8'h5C, drs_pkg::BASE_RW);
    wr(8'h6C, 32'hFFFF_FFFF);
    rd_chk(8'h6C, drs_pkg::MASK_RW);
    wr(8'h78, 32'hFFFF_FFFF);
    rd_chk(8'h78, drs_pkg::CTRL_RW);
    wb(1'b1, 8'h40, 4'b0001, 32'hFFFF_FFFF, q);
    rd_chk(8'h40, 32'h0000_00EF);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, drs_pkg::BASE_RW);
    wr(8'h60, 32'hFFFF_FFFF);
    rd_chk(8'h60, drs_pkg::MASK_RW);
    wr(8'h90, 32'hFFFF_FFFF);
    rd_chk(8'h90, 32'h0000_0000);
    wr(8'h5C, 32'h0);
    wr(8'h6C, 32'h0);
    wr(8'h60, 32'h0);
    wr(8'h40, 32'h0);
    wr(8'h78, 32'h0000_0006);
    $display("test access done");
  endtask : t_access

  task automatic t_match;
    logic [36:0] a;
    logic [36:0] addrs [5];
    logic [7:0] exps [5];
    a = {10'h005, 5'b0_0000, 9'h012, 13'h0000};
    addrs = '{a, a ^ (37'h1 << 27), a ^ (37'h1 << 13), 37'h0, a};
    exps = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h00};
    wr(8'h48, baseVal(10'h005, 9'h012) | 32'h1);
    wr(8'h4C, baseVal(10'h005, 9'h012));
    wr(8'h64, 32'h0008_0000);
    for (int i = 0; i < 5; i++) begin
      // The last request meets a map with every rank disabled.
      if (i == 4) begin
        wr(8'h48, 32'h0);
      end
      @(posedge ref_clk);
      reqValid <= 1'b1;
      reqAddr <= addrs[i];
      @(posedge ref_clk);
      reqValid <= 1'b0;
      #1;
      check({31'h0, selValid}, 32'h1);
      check({24'h0, rankSel}, {24'h0, exps[i]});
    end
    $display("test match done");
  endtask : t_match

  task automatic t_mirror;
    logic [15:0] ea;
    logic [2:0] eb;
    wr(8'h44, 32'h0000_0008);
    for (int i = 0; i < 3; i++) begin
      ea = 16'h00A8;
      eb = 3'b001;
      if (i == 0) begin
        ea = 16'h0150;
        eb = 3'b010;
      end
      @(posedge ref_clk);
      cmdValid <= 1'b1;
      cmdIsModeSet <= (i != 1);
      cmdRank <= (i == 2) ? 3'd0 : 3'd1;
      cmdAddr <= 16'h00A8;
      cmdBank <= 3'b001;
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      @(posedge ref_clk);
      #1;
      check({16'h0, lastAddr}, {16'h0, ea});
      check({29'h0, lastBank}, {29'h0, eb});
    end
    check({24'h0, cmdCount}, 32'h3);
    $display("test mirror done");
  endtask : t_mirror

  task automatic t_flags;
    wr(8'h50, 32'h0000_0002);
    wr(8'h54, 32'h0000_0004);
    #1;
    check({24'h0, reserveOut}, 32'h10);
    check({24'h0, failOut}, 32'h20);
    $display("test flags done");
  endtask : t_flags

  task automatic t_watch(input int lim, input int respAt);
    int n;
    logic seen;
    logic [31:0] q;
    seen = 1'b0;
    wr(8'h78, (32'(lim) << 22) | 32'h6);
    @(posedge ref_clk);
    rdIssue <= 1'b1;
    for (n = 1; n <= 12 && !seen; n++) begin
      @(posedge ref_clk);
      rdIssue <= 1'b0;
      rdResp <= (n == respAt);
      #1;
      seen = (expired === 1'b1);
    end
    rdResp <= 1'b0;
    check({31'h0, seen}, {31'h0, respAt == 0});
    if (respAt == 0) check(n - 2, lim);
    wb(1'b0, 8'h80, 4'hF, 32'h0, q);
    check(q, {22'h0, respAt == 0, 9'h000});
    wb(1'b1, 8'h80, 4'b0010, 32'h0000_0200, q);
    $display("test watch done");
  endtask : t_watch

  //////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    {cyc, stb, we, reqValid, cmdValid, cmdIsModeSet, rdIssue, rdResp} = '0;
    {adr, sel, datI, reqAddr, cmdRank, cmdAddr, cmdBank} = '0;
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_access();
    t_match();
    t_mirror();
    t_flags();
    t_watch(3, 0);
    t_watch(1, 0);
    t_watch(5, 2);
    wrap_up();
  end
endmodule : tb_top
